//--- shared/caf_pkg.sv
// Constants, register map and state types of the CAN acceptance filter
// and bit-timing block. Assumes a single 10 MHz system clock.
// Operation
// [R1] After a complete valid frame lands, compare its identifier to every enabled filter.
// [R2] On a match copy the frame to the filter's buffer; no match, no store. The code keeps a full buffer and sets its overflow flag instead.
// [R3] A cleared mask bit accepts that identifier bit unconditionally.
// [R4] A set mask bit accepts only if filter bit equals identifier bit; all must accept.
// [R5] Legacy mode: filters zero and one under mask zero feed receive buffer zero.
// [R6] Legacy mode: filters two to five under mask one feed receive buffer one.
// [R7] Software keeps propagation plus phase one at least phase two.
// [R8] Software keeps resync jump width no larger than phase two.
// [R9] Bit is one-quantum sync, propagation, phase one, phase two; sample ends phase one.
// [R10] Software should normally use a resync jump width of one quantum.
// [R11] Extended flag set: all 29 identifier bits are filtered, upper eleven on top.
// [R12] Quantum comes from prescaler; value four gives ten clock periods.
package caf_pkg;
  localparam int NFILT = 6;
  localparam int IDW   = 29;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_TIMING = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h08;
  localparam logic [7:0] A_FILT0  = 8'h10;
  localparam logic [7:0] A_FILT5  = 8'h24;
  localparam logic [7:0] A_MASK0  = 8'h28;
  localparam logic [7:0] A_MASK1  = 8'h2C;
  localparam logic [7:0] A_RECEIVE_BUFFER_ZERO   = 8'h30;
  localparam logic [7:0] A_RECEIVE_BUFFER_ONE   = 8'h40;
  localparam logic [7:0] A_RXEND  = 8'h4C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_TIM_EN = 8;
  localparam int TIM_BRP     = 0;
  localparam int TIM_PROP    = 8;
  localparam int TIM_PH1     = 12;
  localparam int TIM_PH2     = 16;
  localparam int TIM_SJW     = 20;
  localparam int ST_FULL     = 0;
  localparam int ST_OVF      = 2;
  localparam int ST_CFG_ERR  = 4;
  localparam int FLT_EXT     = 31;
  localparam int INFO_HIT    = 4;

  // Standard frames only carry identifier bits 28:18
  localparam logic [IDW-1:0] STD_BITS = 29'h1FFC_0000;
  localparam logic [31:0]    RESET_W  = 32'h0000_0000;
  // Sync segment length in quanta
  localparam logic [4:0]     SYNC_TQ  = 5'h01;

  typedef enum logic [0:0] {
    CAF_IDLE  = 1'b0,
    CAF_CHECK = 1'b1
  } caf_st_t;

  typedef struct packed {
    logic             full;
    logic             ovf;
    logic             ext;
    logic [2:0]       hit;
    logic [3:0]       dlc;
    logic [IDW-1:0]   id;
    logic [63:0]      data;
  } caf_rxb_t;

  typedef struct packed {
    caf_st_t                 st;
    logic [NFILT-1:0]        filt_en;
    logic                    tim_en;
    logic [5:0]              brp;
    logic [2:0]              prop;
    logic [2:0]              ph1;
    logic [2:0]              ph2;
    logic [1:0]              resync_jump_width;
    logic [NFILT-1:0][31:0]  filt;
    logic [1:0][IDW-1:0]     mask;
    logic [IDW-1:0]          mab_id;
    logic                    mab_ext;
    logic [3:0]              mab_dlc;
    logic [63:0]             mab_data;
    caf_rxb_t [1:0]          rxb;
    logic [1:0]              stored;
    logic [31:0]             rdata;
    logic [6:0]              pre_cnt;
    logic [4:0]              tq_cnt;
    logic                    tq_tick;
    logic                    bit_start;
    logic                    sample;
  } caf_state_t;
endpackage : caf_pkg

//--- shared/caf_match_if.sv
// Carries filters, masks and the assembled identifier to the match
// engine, and the per-filter hits back. Purely combinational path.
`timescale 1ns/1ps
interface caf_match_if;
  import caf_pkg::*;
  logic [NFILT-1:0][31:0] filt;
  logic [1:0][IDW-1:0]    mask;
  logic [NFILT-1:0]       en;
  logic [IDW-1:0]         id;
  logic                   ext;
  logic [NFILT-1:0]       hit;

  modport ctl (output filt, output mask, output en, output id, output ext, input hit);
  modport eng (input filt, input mask, input en, input id, input ext, output hit);
endinterface : caf_match_if

//--- logic/caf_match_eng.sv
// Acceptance compare of the assembled identifier against all filters.
// Assumes inputs are stable registers; result is read in the same cycle.
`timescale 1ns/1ps
module caf_match_eng
  import caf_pkg::*;
(
  caf_match_if.eng m
);
  // One filter: mask-qualified bitwise equality plus frame-type match
  function automatic logic id_hit(input logic [31:0]    f,
                                  input logic [IDW-1:0] msk,
                                  input logic [IDW-1:0] id,
                                  input logic           ext);
    logic [IDW-1:0] used;
    used = ext ? msk : (msk & STD_BITS); // R11
    // Clear mask bit drops out, set mask bit needs equality
    id_hit = (f[FLT_EXT] == ext) && (((f[IDW-1:0] ^ id) & used) == '0); // R3 R4
  endfunction : id_hit

  always_comb begin
    for (int i = 0; i < NFILT; i++) begin
      // Filters 0..1 use mask 0, the rest mask 1
      m.hit[i] = m.en[i] && id_hit(m.filt[i], m.mask[(i < 2) ? 0 : 1], m.id, m.ext); // R1 R5 R6
    end
  end
endmodule : caf_match_eng

//--- logic/caf_top.sv
// Acceptance filtering into two receive buffers plus nominal bit timing.
// Assumes the protocol engine runs on clk_sys and pulses frame_done once
// per valid frame, at least two cycles apart.
`timescale 1ns/1ps
module caf_top
  import caf_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        frame_done,
  input  wire logic [28:0] frame_id,
  input  wire logic        frame_ext,
  input  wire logic [3:0]  frame_dlc,
  input  wire logic [63:0] frame_data,
  output logic      [1:0]  rx_full,
  output logic      [1:0]  rx_store,
  output logic             tq_tick,
  output logic             bit_start,
  output logic             sample_point
);
  caf_state_t q;
  caf_state_t d;
  caf_match_if mif ();

  caf_match_eng u_eng (
    .m (mif.eng)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Segment fields hold length minus one
  function automatic logic [4:0] seg_len(input logic [2:0] f);
    seg_len = {2'b00, f} + 5'h01;
  endfunction : seg_len

  function automatic logic [31:0] rxb_word(input caf_rxb_t b, input logic [1:0] w);
    case (w)
      2'h0:    rxb_word = {b.ext, 2'b00, b.id};
      2'h1:    rxb_word = {25'h0000000, b.hit, b.dlc};
      2'h2:    rxb_word = b.data[31:0];
      default: rxb_word = b.data[63:32];
    endcase
  endfunction : rxb_word

  logic [4:0] len_prop;
  logic [4:0] len_ph1;
  logic [4:0] len_ph2;
  logic       cfg_err;
  logic [1:0] grp_hit;
  logic [2:0] first;
  logic       tgt;
  logic [31:0] status_w;

  // Misprogramming is only reported; timing runs with what is set
  assign len_prop = seg_len(q.prop);
  assign len_ph1  = seg_len(q.ph1);
  assign len_ph2  = seg_len(q.ph2);
  assign cfg_err  = ((len_prop + len_ph1) < len_ph2) // R7
                  || ({3'b000, q.resync_jump_width} + 5'h01 > len_ph2); // R8

  // ----------------------------------------------------------------
  // Match engine hookup
  // ----------------------------------------------------------------
  // Compare runs on the held copy, so a new frame cannot disturb it
  assign mif.filt = q.filt;
  assign mif.mask = q.mask;
  assign mif.en   = q.filt_en;
  assign mif.id   = q.mab_id;
  assign mif.ext  = q.mab_ext;

  assign grp_hit = {|mif.hit[5:2], |mif.hit[1:0]}; // R5 R6

  // Buffer zero wins when both groups match; lowest filter is reported
  always_comb begin
    first = 3'h0;
    for (int i = NFILT - 1; i >= 0; i--) begin
      if (mif.hit[i]) begin
        first = 3'(i);
      end
    end
  end
  assign tgt = ~grp_hit[0];

  assign status_w = {27'h0000000, cfg_err, q.rxb[1].ovf, q.rxb[0].ovf,
                     q.rxb[1].full, q.rxb[0].full};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d           = q;
    d.stored    = 2'b00;
    d.tq_tick   = 1'b0;
    d.bit_start = 1'b0;
    d.sample    = 1'b0;

    // Register writes; status clears come first so a same-cycle set wins
    if (reg_wr) begin
      if (reg_addr == A_CTRL) begin
        d.filt_en = reg_wdata[NFILT-1:0];
        d.tim_en  = reg_wdata[CTRL_TIM_EN];
      end else if (reg_addr == A_TIMING) begin
        d.brp  = reg_wdata[TIM_BRP +: 6];
        d.prop = reg_wdata[TIM_PROP +: 3];
        d.ph1  = reg_wdata[TIM_PH1 +: 3];
        d.ph2  = reg_wdata[TIM_PH2 +: 3];
        d.resync_jump_width  = reg_wdata[TIM_SJW +: 2];
      end else if (reg_addr == A_STATUS) begin
        for (int b = 0; b < 2; b++) begin
          if (reg_wdata[ST_FULL + b]) begin
            d.rxb[b].full = 1'b0;
          end
          if (reg_wdata[ST_OVF + b]) begin
            d.rxb[b].ovf = 1'b0;
          end
        end
      end else if (reg_addr >= A_FILT0 && reg_addr <= A_FILT5) begin
        d.filt[3'((reg_addr - A_FILT0) >> 2)] = reg_wdata;
      end else if (reg_addr == A_MASK0) begin
        d.mask[0] = reg_wdata[IDW-1:0];
      end else if (reg_addr == A_MASK1) begin
        d.mask[1] = reg_wdata[IDW-1:0];
      end
    end

    // Frame flow: capture, then compare and store in the next cycle
    case (q.st)
      CAF_IDLE: begin
        if (frame_done) begin
          d.mab_id   = frame_id;
          d.mab_ext  = frame_ext;
          d.mab_dlc  = frame_dlc;
          d.mab_data = frame_data;
          d.st       = CAF_CHECK; // R1
        end
      end
      CAF_CHECK: begin
        d.st = CAF_IDLE;
        if (|grp_hit) begin
          // A full buffer is never overwritten; the frame is lost instead
          if (q.rxb[tgt].full) begin
            d.rxb[tgt].ovf = 1'b1;
          end else begin
            d.rxb[tgt].full = 1'b1; // R2
            d.rxb[tgt].ext  = q.mab_ext; // R11
            d.rxb[tgt].hit  = first;
            d.rxb[tgt].dlc  = q.mab_dlc;
            d.rxb[tgt].id   = q.mab_id;
            d.rxb[tgt].data = q.mab_data;
            d.stored[tgt]   = 1'b1;
          end
        end
      end
      default: d.st = CAF_IDLE;
    endcase

    // Quantum is 2*(brp+1) clocks; holding the counter off keeps phase known
    if (!q.tim_en) begin
      d.pre_cnt = 7'h00;
      d.tq_cnt  = 5'h00;
    end else if (q.pre_cnt == {q.brp, 1'b1}) begin // R12
      d.pre_cnt = 7'h00;
      d.tq_tick = 1'b1;
      // Sample point closes phase one
      d.sample  = (q.tq_cnt == SYNC_TQ + len_prop + len_ph1 - 5'h01); // R9
      if (q.tq_cnt == SYNC_TQ + len_prop + len_ph1 + len_ph2 - 5'h01) begin
        d.tq_cnt    = 5'h00;
        d.bit_start = 1'b1; // R9
      end else begin
        d.tq_cnt = q.tq_cnt + 5'h01;
      end
    end else begin
      d.pre_cnt = q.pre_cnt + 7'h01;
    end

    // Read data valid only in the cycle after the strobe
    d.rdata = RESET_W;
    if (reg_rd) begin
      if (reg_addr == A_CTRL) begin
        d.rdata = {23'h000000, q.tim_en, 2'b00, q.filt_en};
      end else if (reg_addr == A_TIMING) begin
        d.rdata = {10'h000, q.resync_jump_width, 1'b0, q.ph2, 1'b0, q.ph1, 1'b0, q.prop, 2'b00, q.brp};
      end else if (reg_addr == A_STATUS) begin
        d.rdata = status_w;
      end else if (reg_addr >= A_FILT0 && reg_addr <= A_FILT5) begin
        d.rdata = q.filt[3'((reg_addr - A_FILT0) >> 2)];
      end else if (reg_addr == A_MASK0) begin
        d.rdata = {3'b000, q.mask[0]};
      end else if (reg_addr == A_MASK1) begin
        d.rdata = {3'b000, q.mask[1]};
      end else if (reg_addr >= A_RECEIVE_BUFFER_ZERO && reg_addr <= A_RXEND) begin
        d.rdata = rxb_word(q.rxb[reg_addr >= A_RECEIVE_BUFFER_ONE], reg_addr[3:2]);
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata    = q.rdata;
  assign rx_full      = {q.rxb[1].full, q.rxb[0].full};
  assign rx_store     = q.stored;
  assign tq_tick      = q.tq_tick;
  assign bit_start    = q.bit_start;
  assign sample_point = q.sample;
endmodule : caf_top

//--- verification/caf_asserts.sv
// Port checker for caf_top, bound from the bench top file.
// Assumes one clock domain and an active high reset.
`timescale 1ns/1ps
module caf_asserts (
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  input wire logic       frame_done,
  input wire logic [1:0] rx_full,
  input wire logic [1:0] rx_store,
  input wire logic       tq_tick,
  input wire logic       bit_start,
  input wire logic       sample_point
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // ----
  // Properties
  // ----
  sequence s_pulse(x);
    x ##1 !x;
  endsequence
  a_store_lat: assert property (|rx_store |-> $past(frame_done, 2))
    else $error("store without frame two cycles before");
  a_store_once: assert property (|rx_store |-> s_pulse(|rx_store))
    else $error("store pulse longer than one cycle");
  a_one_buf: assert property (|rx_store |-> $onehot(rx_store))
    else $error("frame stored in both buffers");
  a_fill_zero: assert property (rx_store[0] |-> rx_full[0] && !$past(rx_full[0]))
    else $error("buffer zero store not into empty buffer");
  a_fill_one: assert property (rx_store[1] |-> rx_full[1] && !$past(rx_full[1]))
    else $error("buffer one store not into empty buffer");
  a_tick_pulse: assert property (tq_tick |-> s_pulse(tq_tick))
    else $error("quantum tick too long");
  a_sample_tick: assert property (sample_point |-> tq_tick && !bit_start)
    else $error("sample point off a quantum edge");
  a_bit_tick: assert property (bit_start |-> tq_tick)
    else $error("bit start off a quantum edge");
endmodule : caf_asserts

//--- verification/caf_eng_model.sv
// Protocol engine stand-in: hands complete frames to the filter block.
// Assumes put is called just after a rising edge of clk_sys.
`timescale 1ns/1ps
module caf_eng_model (
  output logic        frame_done,
  output logic [28:0] frame_id,
  output logic        frame_ext,
  output logic [3:0]  frame_dlc,
  output logic [63:0] frame_data,
  input  wire logic   clk_sys
);
  initial begin
    frame_done = 1'b0;
    frame_id   = 29'h0;
    frame_ext  = 1'b0;
    frame_dlc  = 4'h0;
    frame_data = 64'h0;
  end
  // Fields invert once the frame ends, so a late sample cannot match
  task automatic put(input logic [28:0] id, input logic e, input logic [3:0] l,
                     input logic [63:0] x, input int gap);
    repeat (gap) @(posedge clk_sys);
    frame_done <= 1'b1;
    frame_id   <= id;
    frame_ext  <= e;
    frame_dlc  <= l;
    frame_data <= x;
    @(posedge clk_sys);
    frame_done <= 1'b0;
    frame_id   <= ~id;
    frame_ext  <= ~e;
    frame_dlc  <= ~l;
    frame_data <= ~x;
    @(posedge clk_sys);
  endtask : put
endmodule : caf_eng_model

//--- verification/tb_top.sv
// Bench for caf_top: register bus tasks, engine model, reference model.
// Assumes caf_eng_model and caf_asserts are compiled before it.
`timescale 1ns/1ps
module tb_top;
  import caf_pkg::*;
  logic        clk_sys, sys_rst, reg_wr, reg_rd, frame_done, frame_ext;
  logic        tq_tick, bit_start, sample_point;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, flt[6];
  logic [28:0] frame_id, msk[2];
  logic [3:0]  frame_dlc;
  logic [63:0] frame_data;
  logic [1:0]  rx_full, rx_store, full, ovf;
  int          fails, tests_run;
  caf_top u_dut (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .frame_done, .frame_id, .frame_ext, .frame_dlc, .frame_data, .rx_full, .rx_store,
    .tq_tick, .bit_start, .sample_point);
  caf_eng_model u_eng (.clk_sys, .frame_done, .frame_id, .frame_ext, .frame_dlc,
    .frame_data);
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // ----
  // Tasks
  // ----
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("FAIL %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic chk_rd(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("FAIL %0t read data %h want %h", $time, g, e);
    end
  endtask : chk_rd
  task automatic chk_cnt(input int g, input int e);
    tests_run++;
    if (g != e) begin
      fails++;
      $display("FAIL %0t count %0d want %0d", $time, g, e);
    end
  endtask : chk_cnt
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  function automatic int tgt(input logic [28:0] id, input logic e, input logic [5:0] en,
                             output int h);
    h = -1;
    for (int k = 5; k >= 0; k--)
      if (en[k] && flt[k][31] === e && ((flt[k][28:0] ^ id) & msk[k > 1]
          & (e ? 29'h1FFF_FFFF : STD_BITS)) == 29'h0) h = k;
    return h < 0 ? -1 : int'(h > 1);
  endfunction : tgt
  task automatic frame(input logic [28:0] id, input logic e, input logic [5:0] en);
    int b, h;
    logic st;
    logic [3:0] l;
    logic [63:0] x;
    logic [31:0] d;
    logic [7:0] a;
    l = 4'($urandom);
    x = {$urandom, $urandom};
    if (!e) id &= STD_BITS;
    b = tgt(id, e, en, h);
    st = b >= 0 && !full[b];
    u_eng.put(id, e, l, x, $urandom % 3);
    // The store pulse stands only in the cycle right after put returns
    #1;
    chk(rx_store, st ? 1 << b : 0);
    if (b >= 0) ovf[b] = ovf[b] | full[b];
    if (b >= 0) full[b] = 1'b1;
    chk(rx_full, full);
    rd(A_STATUS, d);
    chk_rd(d[3:0], {ovf, full});
    a = A_RECEIVE_BUFFER_ZERO + 8'(16 * b);
    if (st) begin
      rd(a, d);
      chk_rd(d, {e, 2'b00, id});
      rd(a + 8'h04, d);
      chk_rd(d, {25'h0, 3'(h), l});
      rd(a + 8'h08, d);
      chk_rd(d, x[31:0]);
      rd(a + 8'h0C, d);
      chk_rd(d, x[63:32]);
    end
    d = $urandom & 32'hF;
    wr(A_STATUS, d);
    full &= ~d[1:0];
    ovf &= ~d[3:2];
  endtask : frame
  task automatic bits(input int brp, input int q, input int s);
    int n, t, ts;
    n = 0;
    while (bit_start !== 1'b1 && n < 3000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    n = 0;
    t = 0;
    ts = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
      if (tq_tick === 1'b1) t++;
      if (sample_point === 1'b1) ts = t;
    end while (bit_start !== 1'b1 && n < 3000);
    chk_cnt(n, 2 * (brp + 1) * q);
    chk_cnt(t, q);
    chk_cnt(ts, s);
  endtask : bits
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #3_000_000;
    fails++;
    end_of_test();
  end
  // ----
  // Main sequence
  // ----
  initial begin
    int k, w;
    logic err;
    logic [5:0] en;
    logic [28:0] id;
    logic [31:0] d;
    logic [7:0] ra[7];
    int cf[3][5];
    ra = '{A_CTRL, A_TIMING, A_STATUS, A_FILT0, A_MASK1, A_RECEIVE_BUFFER_ONE, 8'hFC};
    // Bit-time table: brp, prop, ph1, ph2, jump width; the last is misprogrammed
    cf = '{'{4, 2, 7, 6, 4}, '{0, 1, 1, 2, 1}, '{1, 1, 1, 3, 3}};
    {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'b100, 8'h00, 32'h0};
    {full, ovf, fails, tests_run} = '0;
    k = $urandom(78932);
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1;
    foreach (ra[i]) begin
      rd(ra[i], d);
      chk_rd(d, 32'h0);
    end
    for (int r = 0; r < 4; r++) begin
      en = r < 2 ? 6'h3F : 6'($urandom);
      wr(A_CTRL, {26'h0, en});
      for (int g = 0; g < 2; g++) begin
        msk[g] = r == 0 ? 29'h0 : r == 1 ? 29'h1FFF_FFFF : 29'($urandom);
        wr(A_MASK0 + 8'(4 * g), {3'h0, msk[g]});
      end
      for (k = 0; k < 6; k++) begin
        flt[k] = $urandom & 32'h9FFF_FFFF;
        wr(A_FILT0 + 8'(4 * k), flt[k]);
        rd(A_FILT0 + 8'(4 * k), d);
        chk_rd(d, flt[k]);
      end
      for (int i = 0; i < 16; i++) begin
        k = $urandom % 6;
        id = i % 4 ? flt[k][28:0] ^ (29'($urandom) & ~msk[k > 1]) : 29'($urandom);
        frame(id, i % 4 ? flt[k][31] : 1'($urandom), en);
      end
    end
    for (int c = 0; c < 3; c++) begin
      w = cf[c][0] | cf[c][1] - 1 << TIM_PROP | cf[c][2] - 1 << TIM_PH1
        | cf[c][3] - 1 << TIM_PH2 | cf[c][4] - 1 << TIM_SJW;
      err = cf[c][1] + cf[c][2] < cf[c][3] || cf[c][4] > cf[c][3];
      wr(A_CTRL, 32'h0);
      wr(A_TIMING, 32'(w));
      wr(A_CTRL, 32'h100);
      rd(A_STATUS, d);
      chk_rd(d[ST_CFG_ERR], err);
      bits(cf[c][0], 1 + cf[c][1] + cf[c][2] + cf[c][3], 1 + cf[c][1] + cf[c][2]);
    end
    end_of_test();
  end
endmodule : tb_top
bind caf_top caf_asserts u_chk (.clk_sys, .sys_rst, .frame_done, .rx_full, .rx_store,
  .tq_tick, .bit_start, .sample_point);
